// ---- pkg/lcpc_pkg.sv ----
// ==========================================================
// LED channel phase control constants
package lcpc_pkg;

  // ========================================================
  // Bus shape
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_CH = 6;

  // ========================================================
  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_CONFIG = 10'h008;
  localparam logic [9:0] IDX_CHAN = 10'h009;
  localparam logic [9:0] IDX_PHASE = 10'h00a;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h00b;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h00c;
  localparam logic [9:0] IDX_PERIOD = 10'h00d;

  // ========================================================
  // Field positions
  localparam int unsigned CFG_VSC_BIT = 0;
  localparam int unsigned CFG_FSW_BIT = 2;
  localparam int unsigned CFG_DRV_LSB = 3;
  localparam int unsigned PH_EVEN_BIT = 7;

  // ========================================================
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h1f;
  localparam logic [5:0] CHAN_RESET = 6'h3f;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

  // ========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PWM_PERIOD_NS = 100000;
  localparam logic [15:0] PERIOD_RESET =
    16'(PWM_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [22:0] PH_STEP_DIV = 23'h0000ff;

endpackage

// ---- hdl/lcpc_top.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lcpc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lcpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel fault pins
  input wire logic [lcpc_pkg::NUM_CH-1:0] chan_fault_in,
  // Channel control
  output logic [lcpc_pkg::NUM_CH-1:0] chan_active,
  output logic [lcpc_pkg::NUM_CH-1:0] chan_start,
  // Boost configuration
  output logic [1:0] driver_strength_sel,
  output logic switch_freq_sel,
  output logic short_det_en,
  // Interrupt
  output logic irq
);
  import lcpc_pkg::*;

  // ========================================================
  // Helpers
  // Count of set bits in a channel mask
  function automatic logic [2:0] count_ones(input logic [5:0] m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction

  // Mask of channels below index k
  function automatic logic [5:0] low_mask(input int k);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (i < k)
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ========================================================
  // Registers
  logic [7:0] cfg;
  logic [5:0] chan_en;
  logic [7:0] phase;
  logic [5:0] irq_stat;
  logic [5:0] irq_mask;
  logic [15:0] period;
  logic [5:0] fault;
  logic [5:0] flt_s1;
  logic [5:0] flt_s2;
  logic [15:0] pwm_cnt;
  logic [15:0] step_q;

  // ========================================================
  // APB decode
  logic access;
  logic wr_fire;
  logic [9:0] word_idx;
  logic hit_cfg;
  logic hit_chan;
  logic hit_phase;
  logic hit_stat;
  logic hit_mask;
  logic hit_period;
  logic mapped;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] rd_word;

  // Address compare and write strobes
  assign access = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign word_idx = paddr[ADDR_W-1:2];
  assign hit_cfg = (word_idx == IDX_CONFIG);
  assign hit_chan = (word_idx == IDX_CHAN);
  assign hit_phase = (word_idx == IDX_PHASE);
  assign hit_stat = (word_idx == IDX_IRQ_STAT);
  assign hit_mask = (word_idx == IDX_IRQ_MASK);
  assign hit_period = (word_idx == IDX_PERIOD);
  assign mapped = hit_cfg | hit_chan | hit_phase | hit_stat |
    hit_mask | hit_period;
  assign wr_lo = wr_fire & pstrb[0];
  assign wr_hi = wr_fire & pstrb[1];

  // ========================================================
  // Channel state
  logic [5:0] ch_live;
  logic [5:0] next_fault;
  logic [5:0] fault_new;
  logic [5:0] stat_clr;
  logic [5:0] next_irq_stat;

  // Enabled and healthy channels
  assign ch_live = chan_en & ~fault;
  // Latch while enabled, drop when the enable bit is cleared
  assign next_fault = (fault | (chan_en & flt_s2)) & chan_en;
  assign fault_new = chan_en & flt_s2 & ~fault;
  assign stat_clr = (wr_lo & hit_stat) ? pwdata[5:0] : 6'h00;
  // New events win over a clear in the same cycle
  assign next_irq_stat = (irq_stat & ~stat_clr) | fault_new;

  // Read data mux, unused bits read zero
  assign rd_word = hit_cfg ? {24'h000000, cfg} :
    hit_chan ? {26'h0000000, ch_live} :
    hit_phase ? {24'h000000, phase} :
    hit_stat ? {26'h0000000, irq_stat} :
    hit_mask ? {26'h0000000, irq_mask} :
    hit_period ? {16'h0000, period} :
    32'h00000000;

  // ========================================================
  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access & ~pready;
      if (access & ~pready)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
        pslverr <= ~mapped;
      end
    end
  end

  // ========================================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= CFG_RESET;
      chan_en <= CHAN_RESET;
      phase <= PHASE_RESET;
      irq_mask <= IRQ_MASK_RESET;
      period <= PERIOD_RESET;
    end
    else
    begin
      if (wr_lo & hit_cfg)
      begin
        cfg <= pwdata[7:0];
      end
      if (wr_lo & hit_chan)
      begin
        chan_en <= pwdata[5:0];
      end
      if (wr_lo & hit_phase)
      begin
        phase <= pwdata[7:0];
      end
      if (wr_lo & hit_mask)
      begin
        irq_mask <= pwdata[5:0];
      end
      if (wr_lo & hit_period)
      begin
        period[7:0] <= pwdata[7:0];
      end
      if (wr_hi & hit_period)
      begin
        period[15:8] <= pwdata[15:8];
      end
    end
  end

  // ========================================================
  // Fault pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_s1 <= 6'h00;
      flt_s2 <= 6'h00;
    end
    else
    begin
      flt_s1 <= chan_fault_in;
      flt_s2 <= flt_s1;
    end
  end

  // Fault latch, status and interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault <= 6'h00;
      irq_stat <= 6'h00;
      irq <= 1'b0;
      chan_active <= 6'h00;
    end
    else
    begin
      fault <= next_fault;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
      chan_active <= next_fault ^ chan_en;
    end
  end

  // ========================================================
  // Boost configuration pins
  assign driver_strength_sel = cfg[CFG_DRV_LSB+1:CFG_DRV_LSB];
  assign switch_freq_sel = cfg[CFG_FSW_BIT];
  assign short_det_en = cfg[CFG_VSC_BIT];

  // ========================================================
  // Phase step
  logic [2:0] n_live;
  logic [15:0] even_step;
  logic [22:0] prog_prod;
  logic [22:0] prog_step;
  logic [15:0] next_step;
  logic cnt_wrap;
  logic [15:0] next_cnt;

  // Step from count of live channels or from the programmed value
  assign n_live = count_ones(ch_live);
  assign even_step = (n_live == 3'h0) ? 16'h0000 :
    period / {13'h0000, n_live};
  assign prog_prod = {16'h0000, phase[6:0]} * {7'h00, period};
  assign prog_step = prog_prod / PH_STEP_DIV;
  assign next_step = phase[PH_EVEN_BIT] ? even_step :
    prog_step[15:0];
  // Period counter runs 0 to period-1
  assign cnt_wrap = (period < 16'h0002) ||
    (pwm_cnt >= 16'(period - 16'h0001));
  assign next_cnt = cnt_wrap ? 16'h0000 : 16'(pwm_cnt + 16'h0001);

  // Counter, step taken only at the period boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_cnt <= 16'h0000;
      step_q <= 16'h0000;
    end
    else
    begin
      pwm_cnt <= next_cnt;
      if (cnt_wrap)
      begin
        step_q <= next_step;
      end
    end
  end

  // ========================================================
  // Per channel start points
  logic [5:0] start_hit;

  for (genvar k = 0; k < NUM_CH; k++)
  begin : g_ch
    logic [2:0] rank;
    logic [18:0] delay;
    // Rank among live channels of lower index
    assign rank = count_ones(ch_live & low_mask(k));
    assign delay = {16'h0000, rank} * {3'h0, step_q};
    // Beyond one period no start occurs
    assign start_hit[k] = ch_live[k] &
      (delay == {3'h0, pwm_cnt});
  end

  // Registered start pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_start <= 6'h00;
    end
    else
    begin
      chan_start <= start_hit;
    end
  end

endmodule
`default_nettype wire

// ---- sim/lcpc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus and channel checks
module lcpc_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lcpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channels and configuration
  input wire logic [lcpc_pkg::NUM_CH-1:0] chan_fault_in,
  input wire logic [lcpc_pkg::NUM_CH-1:0] chan_active,
  input wire logic [lcpc_pkg::NUM_CH-1:0] chan_start,
  input wire logic [1:0] driver_strength_sel,
  input wire logic switch_freq_sel,
  input wire logic short_det_en
);
  import lcpc_pkg::*;
  wire logic [9:0] idx;
  wire logic cfg_wr;
  // Word index and configuration write strobe
  assign idx = paddr[11:2];
  assign cfg_wr = psel && penable && pready && pwrite && idx == IDX_CONFIG;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_fault_held;
    chan_fault_in[2] [*5];
  endsequence
  chk_ready_wait: assert property (s_access |=> pready)
    else $error("ready late after access start");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_map: assert property (pready |->
    pslverr == (idx < IDX_CONFIG || idx > IDX_PERIOD))
    else $error("error flag wrong for address");
  chk_chan_rdzero: assert property (
    pready && !pwrite && idx == IDX_CHAN |-> prdata[31:6] == 26'h0)
    else $error("mask readback upper bits set");
  chk_fault_drop: assert property (
    s_fault_held |-> !chan_active[2]) else $error("fault not latched");
  chk_act_reset: assert property (
    $rose(presetn) |=> chan_active == 6'h3f)
    else $error("channels not enabled after reset");
  chk_cfg_reset: assert property (
    $rose(presetn) |-> driver_strength_sel == 2'b11 && switch_freq_sel
    && short_det_en) else $error("config reset value wrong");
  chk_cfg_cause: assert property (
    !$stable({driver_strength_sel, switch_freq_sel, short_det_en})
    |-> $past(cfg_wr)) else $error("config changed without a write");
  chk_start_pulse: assert property ((chan_start & $past(chan_start)) == 0)
    else $error("start longer than one cycle");
endmodule
bind lcpc_top lcpc_monitor i_mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .chan_fault_in(chan_fault_in),
  .chan_active(chan_active),
  .chan_start(chan_start),
  .driver_strength_sel(driver_strength_sel),
  .switch_freq_sel(switch_freq_sel),
  .short_det_en(short_det_en)
);
`default_nettype wire

// ---- sim/lcpc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host bus master model
module lcpc_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [lcpc_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import lcpc_pkg::*;
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end
  // Setup, access held until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic err,
    output bit ok);
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- sim/lcpc_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for channel mask, faults and phase
module lcpc_bench;
  import lcpc_pkg::*;
  localparam int P = 255;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, e, ok;
  logic switch_freq_sel, short_det_en;
  logic [1:0] driver_strength_sel;
  logic [3:0] pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [5:0] chan_fault_in = 6'h00;
  logic [5:0] chan_active, chan_start;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int last [6];
  lcpc_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chan_fault_in(chan_fault_in),
    .chan_active(chan_active),
    .chan_start(chan_start),
    .driver_strength_sel(driver_strength_sel),
    .switch_freq_sel(switch_freq_sel),
    .short_det_en(short_det_en),
    .irq(irq)
  );
  lcpc_host i_host (
    .pclk(pclk),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );
  // Bus clock
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  // Cycle of the latest start pulse per channel
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < 6; k++)
      if (chan_start[k] === 1'b1)
        last[k] <= cyc;
  end
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // One transfer; a hang ends the run
  task automatic io(input logic w, input logic [9:0] i, input logic [31:0] d);
    i_host.xfer(w, {i, 2'b00}, d, q, e, ok);
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("mismatch at %0t: no bus answer", $time);
      stop_test();
    end
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] x);
    io(1'b0, i, 32'h0);
    chk(q, x);
  endtask
  // Offset of channel k from the lowest enabled one
  function automatic int exp_off(logic [5:0] m, logic ev, int ps, int k);
    int n = $countones(m);
    int r = $countones(m & ((6'h01 << k) - 6'h01));
    return r * (ev ? P / n : ps * P / 255);
  endfunction
  task automatic phase(input logic [5:0] m, input logic ev, input int ps);
    int lo = 0;
    io(1'b1, IDX_CHAN, 32'(m));
    io(1'b1, IDX_PHASE, 32'({ev, ps[6:0]}));
    repeat (3 * P) @(posedge pclk);
    while (!m[lo])
      lo++;
    for (int k = 0; k < 6; k++)
      if (m[k])
        chk(32'(((last[k] - last[lo]) % P + P) % P),
          32'(exp_off(m, ev, ps, k)));
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h5e136e50));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CONFIG, 32'h1f);
    rd(IDX_CHAN, 32'h3f);
    rd(IDX_PHASE, 32'h0);
    rd(10'h3f0, 32'h0);
    chk(32'(e), 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      v = $urandom_range(0, 255);
      v[4:3] = c[1:0];
      io(1'b1, IDX_CONFIG, v);
      #1 chk(32'({driver_strength_sel, switch_freq_sel, short_det_en}),
        32'({v[4:2], v[0]}));
      rd(IDX_CONFIG, v & 32'hff);
    end
    for (int c = 0; c < 6; c++)
    begin
      v = $urandom;
      io(1'b1, IDX_CHAN, v);
      rd(IDX_CHAN, v & 32'h3f);
      #1 chk(32'(chan_active), v & 32'h3f);
    end
    io(1'b1, IDX_CHAN, 32'h3f);
    chan_fault_in <= 6'h04;
    repeat (6) @(posedge pclk);
    #1 chk(32'({irq, chan_active}), 32'h3b);
    io(1'b1, IDX_IRQ_MASK, 32'h04);
    // Interrupt is registered, it follows the mask one edge later
    @(posedge pclk);
    #1 chk(32'(irq), 32'h1);
    rd(IDX_CHAN, 32'h3b);
    rd(IDX_IRQ_STAT, 32'h04);
    chan_fault_in <= 6'h00;
    io(1'b1, IDX_CHAN, 32'h3f);
    rd(IDX_CHAN, 32'h3b);
    io(1'b1, IDX_CHAN, 32'h3b);
    #1 chk(32'(chan_active), 32'h3b);
    io(1'b1, IDX_CHAN, 32'h3f);
    rd(IDX_CHAN, 32'h3f);
    io(1'b1, IDX_IRQ_STAT, 32'h04);
    #1 chk(32'(irq), 32'h0);
    io(1'b1, IDX_PERIOD, 32'(P));
    // Spread stays inside one period
    phase(6'h3f, 1'b0, 20);
    phase(6'h2d, 1'b1, 0);
    phase(6'h3f, 1'b1, 0);
    for (int c = 0; c < 3; c++)
      phase(6'($urandom_range(1, 63)), 1'($urandom),
        $urandom_range(0, 50));
    stop_test();
  end
endmodule
`default_nettype wire
